/* File: src/cap_alu_pointer_ops.sv */
// Execution datapath for accumulator, register file and file pointers,
// reached as an AHB-Lite slave. Assumes a single slave on the bus, so
// hready is this block's own hreadyout fed back.
// Only whole-word single transfers are expected, so hsize is not decoded.
//
// Behaviour
// [RQ1] PC change or true test costs two cycles, second one a no-op.
// [RQ2] Indirect access with pointer MSb set takes one extra cycle.
// [RQ3] Pointer add sign-extends 6-bit literal onto pointer 0 or 1, flags kept.
// [RQ4] Pointer wraps modulo 2^16, never saturates.
// [RQ5] AND immediate: acc AND literal into acc, only zero flag.
// [RQ6] Add immediate: acc plus literal into acc, updates C, DC, Z.
// [RQ7] AND register: result to acc if d=0, to register if d=1; Z only.
// [RQ8] Add register: sum to acc or register by d; updates C, DC, Z.
// [RQ9] Arithmetic shift right: bit 7 kept, old bit 0 into carry; C, Z.
// [RQ10] Pointer add decoded from 11 0001 0nkk kkkk, one cycle.
// [RQ11] Z on zero result; C from bit 7, DC from bit 3 carry.
`include "cap_map.svh"
`timescale 1ns/1ps
`default_nettype none

module cap_alu_pointer_ops #(
  // Width of each file pointer
  parameter int PTR_W = 16,
  // Width of the signed pointer-add literal
  parameter int LIT_W = 6
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite address and control
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  // AHB-Lite data and response
  input  wire logic [31:0] hwdata,
  output var  logic [31:0] hrdata,
  output var  logic        hreadyout,
  output var  logic        hresp
);
  import cap_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0]            mem [128];
  logic [7:0]            acc;
  cap_flags_type         flg;
  logic [1:0][PTR_W-1:0] ptr;
  logic [1:0]            ctl;
  logic [1:0]            last_cyc;
  logic [13:0]           op;
  cap_state_type         st;
  cap_dphase_type        dph;
  logic                  busy;
  logic                  bus_wr;
  logic                  go;

  // Any state but IDLE means an instruction is still in flight.
  assign busy   = (st != CAP_IDLE);
  assign bus_wr = dph.act & dph.wr & ~busy;
  assign go     = bus_wr & (dph.addr == `CAP_OFS_OPCODE);

  // ----------------------------------------------------------------------
  // Decode and datapath
  // ----------------------------------------------------------------------
  logic        is_file;
  logic        ind;
  logic        psel;
  logic [6:0]  ea;
  logic [7:0]  opnd;
  logic [7:0]  res;
  logic [8:0]  sum;
  logic [4:0]  nib;
  logic [7:0]  rhs;
  logic        is_add;
  logic        wr_acc;
  logic        wr_mem;
  logic        do_ptr;
  logic        xtra;
  logic        two;
  cap_flags_type next_flg;
  logic [PTR_W-1:0] next_ptr;

  // The operand is read from the file in the EXEC cycle itself. The two
  // indirect slots take their file address from the pointer's low bits,
  // so a pointer beyond the file only aliases; it never faults.
  always_comb begin
    is_file  = 1'b0;
    is_add   = 1'b0;
    wr_acc   = 1'b0;
    wr_mem   = 1'b0;
    do_ptr   = 1'b0;
    res      = acc;
    next_flg = flg;
    ind      = (op[6:0] == `CAP_IND0) | (op[6:0] == `CAP_IND1);
    psel     = op[0];
    // Indirect slots reach the file through the low bits of the pointer.
    ea       = ind ? ptr[psel][6:0] : op[6:0];
    opnd     = mem[ea];
    rhs      = op[13:8] == `CAP_OP_ADDLIT ? op[7:0] : opnd;
    sum      = {1'b0, acc} + {1'b0, rhs};
    nib      = {1'b0, acc[3:0]} + {1'b0, rhs[3:0]};
    // Pointer add: the 16-bit sum drops its carry, so it wraps. // RQ4
    next_ptr = ptr[op[6]]
             + {{(PTR_W - LIT_W){op[LIT_W - 1]}}, op[LIT_W - 1:0]}; // RQ3
    if (op[13:7] == `CAP_OP_PTRADD) begin // RQ10
      do_ptr = 1'b1; // RQ3
    end else begin
      unique case (op[13:8])
        `CAP_OP_ADDLIT: begin
          res    = sum[7:0]; // RQ6
          is_add = 1'b1;
          wr_acc = 1'b1;
        end
        `CAP_OP_ANDLIT: begin
          res    = acc & op[7:0]; // RQ5
          wr_acc = 1'b1;
        end
        `CAP_OP_ANDREG: begin
          res     = acc & opnd; // RQ7
          is_file = 1'b1;
        end
        `CAP_OP_ADDREG: begin
          res     = sum[7:0]; // RQ8
          is_add  = 1'b1;
          is_file = 1'b1;
        end
        `CAP_OP_ASR: begin
          res       = {opnd[7], opnd[7:1]}; // RQ9
          next_flg.c = opnd[0]; // RQ9
          is_file   = 1'b1;
        end
        default: begin
          res = acc;
        end
      endcase
      // Register forms pick their destination from the d bit.
      if (is_file) begin
        wr_acc = ~op[7]; // RQ7 RQ8 RQ9
        wr_mem = op[7];
      end
      if (is_add) begin
        next_flg.c  = sum[8]; // RQ11
        next_flg.dc = nib[4]; // RQ11
      end
      // Only opcodes that write a result touch the zero flag.
      if (wr_acc | wr_mem) begin
        next_flg.z = (res == 8'h00); // RQ11
      end
    end
    xtra = is_file & ind & ptr[psel][PTR_W - 1]; // RQ2
    two  = ctl[`CAP_CTL_PCMOD] | ctl[`CAP_CTL_COND]; // RQ1
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // One state per instruction cycle. Results land on the EXEC edge; XTRA
  // and NOP only stretch the busy time, for the extra fetch of an indirect
  // access through a high pointer and for the discarded second cycle.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st       <= CAP_IDLE;
      op       <= `CAP_OP_RST;
      last_cyc <= 2'h0;
    end else begin
      unique case (st)
        CAP_IDLE: begin
          if (go) begin
            op <= hwdata[13:0];
            st <= CAP_EXEC;
          end
        end
        CAP_EXEC: begin
          last_cyc <= 2'h1 + {1'b0, xtra} + {1'b0, two};
          if (xtra) begin
            st <= CAP_XTRA; // RQ2
          end else if (two) begin
            st <= CAP_NOP; // RQ1
          end else begin
            st <= CAP_IDLE;
          end
        end
        CAP_XTRA: begin
          st <= two ? CAP_NOP : CAP_IDLE;
        end
        CAP_NOP: begin
          st <= CAP_IDLE; // RQ1
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Architectural registers
  // ----------------------------------------------------------------------
  // Bus writes are stalled while busy, so the two writers never collide.
  // The flags follow every executed opcode, so a pointer add or an unknown
  // opcode simply writes them back unchanged.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc <= `CAP_ACC_RST;
      flg <= `CAP_FLAGS_RST;
      ctl <= 2'h0;
    end else if (st == CAP_EXEC) begin
      if (wr_acc) begin
        acc <= res;
      end
      flg <= next_flg; // RQ3
    end else if (bus_wr) begin
      if (dph.addr == `CAP_OFS_ACC) begin
        acc <= hwdata[7:0];
      end
      if (dph.addr == `CAP_OFS_FLAGS) begin
        flg <= hwdata[2:0];
      end
      if (dph.addr == `CAP_OFS_CTL) begin
        ctl <= hwdata[1:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // File pointers and register file
  // ----------------------------------------------------------------------
  // A pointer update from the datapath wins over a bus write, which in any
  // case cannot land while an instruction is running.
  for (genvar i = 0; i < 2; i++) begin : g_ptr
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        ptr[i] <= PTR_W'(`CAP_PTR_RST);
      end else if (st == CAP_EXEC && do_ptr && op[6] == 1'(i)) begin
        ptr[i] <= next_ptr; // RQ3 RQ4
      end else if (bus_wr && dph.addr == `CAP_OFS_PTR0 + 10'(4 * i)) begin
        ptr[i] <= hwdata[PTR_W-1:0];
      end
    end
  end

  // The file has no reset; software must initialise what it reads.
  // Leaving it unreset keeps it a plain memory array instead of flops.
  always_ff @(posedge hclk) begin
    if (st == CAP_EXEC && wr_mem) begin
      mem[ea] <= res; // RQ7 RQ8 RQ9
    end else if (bus_wr && dph.addr[`CAP_MEM_SEL_BIT] == `CAP_MEM_SEL) begin
      mem[dph.addr[8:2]] <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;

  // Unused upper bits read as zero, so software needs no masking.
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (dph.addr[`CAP_MEM_SEL_BIT] == `CAP_MEM_SEL) begin
      rd_mux[7:0] = mem[dph.addr[8:2]];
    end else begin
      unique case (dph.addr)
        `CAP_OFS_OPCODE: rd_mux[13:0] = op;
        `CAP_OFS_ACC:    rd_mux[7:0]  = acc;
        `CAP_OFS_FLAGS:  rd_mux[2:0]  = flg;
        `CAP_OFS_PTR0:   rd_mux[PTR_W-1:0] = ptr[0];
        `CAP_OFS_PTR1:   rd_mux[PTR_W-1:0] = ptr[1];
        `CAP_OFS_CTL:    rd_mux[1:0]  = ctl;
        `CAP_OFS_STAT: begin
          rd_mux[`CAP_STAT_BUSY]  = busy;
          rd_mux[`CAP_STAT_CYC+:2] = last_cyc;
        end
        default:         rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Every transfer takes one wait state; writes wait for the sequencer.
  // Reads are never stalled: only a write could race the datapath's own
  // update, so only a write waits. Read data stands until the next read.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph       <= '0;
      hreadyout <= 1'b1;
      hrdata    <= 32'h0000_0000;
      hresp     <= 1'b0;
    end else begin
      hresp <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        dph       <= {1'b1, hwrite, haddr[9:0]};
        hreadyout <= 1'b0;
      end else if (dph.act && !(dph.wr && busy)) begin
        dph.act   <= 1'b0;
        hreadyout <= 1'b1;
        if (!dph.wr) begin
          hrdata <= rd_mux;
        end
      end
    end
  end

endmodule

`default_nettype wire

/* File: src/cap_map.svh */
// Offsets, field positions, reset values and opcode patterns of the
// execution block. Assumes a 10-bit decoded slice of the bus address.
`ifndef CAP_MAP_SVH
`define CAP_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define CAP_ADDR_W      10
`define CAP_OFS_OPCODE  10'h000
`define CAP_OFS_ACC     10'h004
`define CAP_OFS_FLAGS   10'h008
`define CAP_OFS_PTR0    10'h00C
`define CAP_OFS_PTR1    10'h010
`define CAP_OFS_CTL     10'h014
`define CAP_OFS_STAT    10'h018
`define CAP_MEM_SEL     1'h1
`define CAP_MEM_SEL_BIT 9

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CAP_CTL_PCMOD   0
`define CAP_CTL_COND    1
`define CAP_STAT_BUSY   0
`define CAP_STAT_CYC    1
`define CAP_ACC_RST     8'h00
`define CAP_PTR_RST     16'h0000
`define CAP_FLAGS_RST   3'h0
`define CAP_OP_RST      14'h0000

// ----------------------------------------------------------------------
// Opcode patterns and indirect access addresses
// ----------------------------------------------------------------------
`define CAP_OP_ADDLIT   6'h3E
`define CAP_OP_ANDLIT   6'h39
`define CAP_OP_PTRADD   7'h62
`define CAP_OP_ANDREG   6'h05
`define CAP_OP_ADDREG   6'h07
`define CAP_OP_ASR      6'h37
`define CAP_IND0        7'h00
`define CAP_IND1        7'h01

`endif

/* File: src/cap_pkg.sv */
// Types shared by the execution block and its bench.
// Assumes cap_map.svh supplies the numeric constants.
package cap_pkg;

  // Status flags carried together.
  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } cap_flags_type;

  // Execution sequencer, one-hot.
  typedef enum logic [3:0] {
    CAP_IDLE = 4'b0001,
    CAP_EXEC = 4'b0010,
    CAP_XTRA = 4'b0100,
    CAP_NOP  = 4'b1000
  } cap_state_type;

  // Captured bus address phase.
  typedef struct packed {
    logic       act;
    logic       wr;
    logic [9:0] addr;
  } cap_dphase_type;

endpackage

/* File: bench/cap_alu_monitor.sv */
// Bus-side checker for the execution block.
// Assumes hready is the block's own hreadyout fed back.
`timescale 1ns/1ps
`default_nettype none
`include "cap_map.svh"
module cap_alu_monitor (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp
);
  import cap_pkg::*;
  logic       tk;
  logic       rd;
  logic [9:0] ra;
  assign tk = hsel & htrans[1] & hready;
  // Remember the read in its data phase, to know when hrdata may move.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd <= 1'b0;
      ra <= 10'h000;
    end else begin
      rd <= tk & ~hwrite;
      ra <= haddr[9:0];
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_turn;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_rd(a);
    rd && ra == a;
  endsequence
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not OKAY");
  chk_read_turn: assert property (tk && !hwrite |=> s_turn)
    else $error("read not answered after one wait");
  chk_write_bound: assert property (
    tk && hwrite |=> !hreadyout ##[1:5] hreadyout)
    else $error("write wait too long");
  chk_idle_ready: assert property (hreadyout && !tk |=> hreadyout)
    else $error("ready dropped without a transfer");
  chk_rdata_hold: assert property (!rd |=> $stable(hrdata))
    else $error("read data moved outside a read");
  chk_acc_width: assert property (
    s_rd(`CAP_OFS_ACC) |=> hrdata[31:8] == 24'h000000)
    else $error("accumulator wider than a byte");
  chk_ptr_width: assert property (
    s_rd(`CAP_OFS_PTR0) or s_rd(`CAP_OFS_PTR1)
    |=> hrdata[31:16] == 16'h0000)
    else $error("pointer beyond 16 bits");
  chk_flag_width: assert property (
    s_rd(`CAP_OFS_FLAGS) |=> hrdata[31:3] == 29'h0)
    else $error("stray flag bits");
endmodule
bind cap_alu_pointer_ops cap_alu_monitor mon (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
  .hready, .hrdata, .hreadyout, .hresp
);
`default_nettype wire

/* File: bench/cap_alu_pointer_ops_bench.sv */
// Self-checking bench with a reference model of the execution block.
// Assumes the block is the only slave, so hready is hreadyout.
`timescale 1ns/1ps
`default_nettype none
`include "cap_map.svh"
module cap_alu_pointer_ops_bench;
  import cap_pkg::*;
  logic          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic [31:0]   haddr, hwdata, hrdata, q, rn;
  logic [13:0]   op;
  int            err_count, cmp_count, seed;
  logic [7:0]    acc;
  logic [7:0]    mem [128];
  logic [15:0]   ptr [2];
  logic [5:0]    opt [5];
  cap_flags_type fl;
  assign hready = hreadyout;
  cap_alu_pointer_ops dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hready, .hwdata, .hrdata, .hreadyout, .hresp);
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // ----------------------------------------------------------------
  // Bus tasks and model
  // ----------------------------------------------------------------
  task stop_test;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  // Sampling at the falling edge sees what the next rising edge sees.
  task hold;
    int   n;
    logic r;
    n = 0;
    do begin
      @(negedge hclk);
      r = hready;
      q = hrdata;
      @(posedge hclk);
      n++;
      if (n > 40) begin
        err_count++;
        stop_test;
      end
    end while (r !== 1'b1);
  endtask
  task bus(logic w, logic [9:0] a, logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {22'h0, a};
    hold;
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    hold;
  endtask
  task rdc(string n, logic [9:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, q, e);
  endtask
  task ex(logic [13:0] o, logic [1:0] ctl);
    logic [8:0] s;
    logic [4:0] h;
    logic [7:0] b, r;
    logic [6:0] ix;
    logic       rg;
    int         cyc;
    rg = o[13:8] inside {`CAP_OP_ANDREG, `CAP_OP_ADDREG, `CAP_OP_ASR};
    ix = rg ? o[6:0] : 7'h02;
    cyc = 1 + (ctl != 2'b00);
    if (rg && o[6:1] == 6'h00) begin
      ix = ptr[o[0]][6:0];
      cyc += ptr[o[0]][15];
    end
    b = rg ? mem[ix] : o[7:0];
    s = {1'b0, acc} + {1'b0, b};
    h = {1'b0, acc[3:0]} + {1'b0, b[3:0]};
    r = acc & b;
    if (o[13:8] inside {`CAP_OP_ADDLIT, `CAP_OP_ADDREG}) begin
      r = s[7:0];
      fl.c = s[8];
      fl.dc = h[4];
    end else if (o[13:8] == `CAP_OP_ASR) begin
      r = {b[7], b[7:1]};
      fl.c = b[0];
    end
    if (o[13:7] == `CAP_OP_PTRADD) begin
      ptr[o[6]] += {{10{o[5]}}, o[5:0]};
    end else if (rg || o[13:8] inside {`CAP_OP_ADDLIT, `CAP_OP_ANDLIT}) begin
      fl.z = (r == 8'h00);
      if (rg && o[7]) mem[ix] = r;
      else acc = r;
    end
    bus(1'b1, `CAP_OFS_CTL, {30'h0, ctl});
    bus(1'b1, `CAP_OFS_OPCODE, {18'h0, o});
    // Repeated after the opcode; only a three-cycle instruction is still busy then, so only then is this write stalled.
    bus(1'b1, `CAP_OFS_CTL, {30'h0, ctl});
    rdc("stat", `CAP_OFS_STAT, 32'(cyc * 2));
    rdc("acc", `CAP_OFS_ACC, {24'h0, acc});
    rdc("flags", `CAP_OFS_FLAGS, {29'h0, fl});
    rdc("ptr0", `CAP_OFS_PTR0, {16'h0, ptr[0]});
    rdc("ptr1", `CAP_OFS_PTR1, {16'h0, ptr[1]});
    rdc("file", {1'b1, ix, 2'b00}, {24'h0, mem[ix]});
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h3368;
    err_count = 0;
    cmp_count = 0;
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    opt = '{`CAP_OP_ADDLIT, `CAP_OP_ANDLIT, `CAP_OP_ANDREG,
            `CAP_OP_ADDREG, `CAP_OP_ASR};
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 6; i++) rdc("reset", 10'(4 * i), 32'h0);
    bus(1'b1, 10'h1F0, 32'hFFFFFFFF);
    rdc("unmapped", 10'h1F0, 32'h0);
    fl = '0;
    for (int f = 2; f < 128; f++) begin
      mem[f] = 8'($random(seed));
      bus(1'b1, {1'b1, 7'(f), 2'b00}, {24'h0, mem[f]});
    end
    ptr = '{16'hFFF6, 16'h0005};
    acc = 8'($random(seed));
    bus(1'b1, `CAP_OFS_PTR0, {16'h0, ptr[0]});
    bus(1'b1, `CAP_OFS_PTR1, {16'h0, ptr[1]});
    bus(1'b1, `CAP_OFS_ACC, {24'h0, acc});
    for (int i = 0; i < 60; i++) begin
      rn = $random(seed);
      op = {opt[i % 5], rn[7:0]};
      if (i % 6 == 5) op = {`CAP_OP_PTRADD, rn[6:0]};
      if (rn[8]) op[6:1] = 6'h00;
      if (op[6:1] == 6'h00 && ptr[op[0]][6:0] < 7'h02) op[6:1] = 6'h01;
      if (i % 6 == 5) op[5:0] = rn[9] ? 6'h20 : 6'h1F;
      ex(op, rn[13:12]);
    end
    // An opcode outside the set must change nothing but the cycle count.
    ex(14'h0155, 2'b11);
    stop_test;
  end
endmodule
`default_nettype wire
